// [irx_pkg.sv]
// Register map, field positions and reset values for the iso receive mask and event bank
package irx_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_UPPER_SET  = 8'h70;
    localparam logic [7:0] OFS_UPPER_CLR  = 8'h74;
    localparam logic [7:0] OFS_LOWER_SET  = 8'h78;
    localparam logic [7:0] OFS_LOWER_CLR  = 8'h7C;
    localparam logic [7:0] OFS_EVENT_SET  = 8'h80;
    localparam logic [7:0] OFS_EVENT_CLR  = 8'h84;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h88;
    localparam logic [7:0] OFS_GPIO_CTRL  = 8'hFC;
    localparam logic [7:0] OFS_RAW_EVENT  = 8'h8C;

    // Event bit positions
    localparam int unsigned EV_GP_INPUT = 30;
    localparam int unsigned EV_SOFTWARE = 29;

    // Enable bits in the general-purpose control register
    localparam int unsigned GP_IRQ_B_EN_BIT = 31;
    localparam int unsigned GP_IRQ_A_EN_BIT = 23;

    // Bits of the event register that exist; 31 and 28 are reserved
    localparam logic [31:0] EVENT_IMPL = 32'h6FFF_FFFF;
    localparam logic [31:0] GPIO_IMPL  = 32'h8080_0000;

    localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage

// [irx_setclr_reg.sv]
// One set/clear register pair with write-one semantics
`timescale 1ns/1ps
module irx_setclr_reg
    import irx_pkg::*;
#(
    parameter int unsigned         W     = 32,
    parameter logic [W-1:0]        IMPL  = '1,
    parameter logic [W-1:0]        RST   = '0
) (
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    // Write-one strobes
    input  wire logic         set_we_i,
    input  wire logic         clr_we_i,
    input  wire logic [W-1:0] wdata_i,
    // Hardware set requests
    input  wire logic [W-1:0] hw_set_i,
    // Stored value
    output logic      [W-1:0] value_o
);
    logic [W-1:0] value_q;
    logic [W-1:0] set_v;
    logic [W-1:0] clr_v;

    // Zero bits leave stored bits alone; a set beats a clear in the same cycle
    always_comb begin
        set_v = hw_set_i | (set_we_i ? wdata_i : '0);
        clr_v = clr_we_i ? wdata_i : '0;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            value_q <= RST;
        end else begin
            value_q <= ((value_q & ~clr_v) | set_v) & IMPL;
        end
    end

    assign value_o = value_q;
endmodule

// [irx_edge_det.sv]
// Rising edge detector for a vector of interrupt sources
`timescale 1ns/1ps
module irx_edge_det
    import irx_pkg::*;
#(
    parameter int unsigned W = 32
) (
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    // Source levels and their asserting edges
    input  wire logic [W-1:0] level_i,
    output logic      [W-1:0] rise_o
);
    logic [W-1:0] prev_q;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            prev_q <= '0;
        end else begin
            prev_q <= level_i;
        end
    end

    assign rise_o = level_i & ~prev_q;
endmodule

// [irx_regs.sv]
// Iso receive channel masks, interrupt event and mask registers, with host port
// Functional notes
// - Upper mask reads the same through both aliases; write one sets or clears a bit.
// - Upper mask bit n enables iso receive on channel 32 plus n.
// - Lower mask is a set/clear pair at its own two offsets covering channels 0 to 31.
// - Lower mask bit n enables receive on channel n; a zero bit rejects it.
// - An event bit sets on a source rising edge or a one written to the set alias.
// - An event bit clears only on a one written to the clear alias.
// - Reading the event register returns event bits ANDed with the interrupt mask.
// - Event bit 30 is the added general-purpose input event; other bits keep their layout.
// - Bit 30 latches when the OR of the enabled general-purpose inputs rises.
`timescale 1ns/1ps
module irx_regs
    import irx_pkg::*;
#(
    parameter int unsigned NUM_CH = 64
) (
    // Clock and reset
    input  wire logic                    clock_i,
    input  wire logic                    rst_i,
    // Host register port
    input  wire logic [ADDR_W-1:0]       addr_i,
    input  wire logic [DATA_W-1:0]       wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    output logic      [DATA_W-1:0]       rdata_o,
    // Interrupt sources and general-purpose inputs
    input  wire logic [DATA_W-1:0]       irq_src_i,
    input  wire logic                    gp_irq_a_i,
    input  wire logic                    gp_irq_b_i,
    // Receive path channel filter
    input  wire logic [5:0]              rx_chan_i,
    output logic                         rx_chan_ok_o,
    output logic      [NUM_CH-1:0]       iso_rx_enable_o,
    // Interrupt output
    output logic                         irq_o
);
    // ==========================================================
    // Address decode
    logic we_up_set;
    logic we_up_clr;
    logic we_lo_set;
    logic we_lo_clr;
    logic we_ev_set;
    logic we_ev_clr;

    always_comb begin
        we_up_set = wr_i && (addr_i == OFS_UPPER_SET);
        we_up_clr = wr_i && (addr_i == OFS_UPPER_CLR);
        we_lo_set = wr_i && (addr_i == OFS_LOWER_SET);
        we_lo_clr = wr_i && (addr_i == OFS_LOWER_CLR);
        we_ev_set = wr_i && (addr_i == OFS_EVENT_SET);
        we_ev_clr = wr_i && (addr_i == OFS_EVENT_CLR);
    end

    // ==========================================================
    // Channel masks
    logic [DATA_W-1:0] upper_mask;
    logic [DATA_W-1:0] lower_mask;

    irx_setclr_reg #(
        .W    (DATA_W),
        .IMPL ({DATA_W{1'b1}}),
        .RST  (RST_ZERO)
    ) u_upper (
        .clock_i  (clock_i),
        .rst_i    (rst_i),
        .set_we_i (we_up_set),
        .clr_we_i (we_up_clr),
        .wdata_i  (wdata_i),
        .hw_set_i (RST_ZERO),
        .value_o  (upper_mask)
    );

    irx_setclr_reg #(
        .W    (DATA_W),
        .IMPL ({DATA_W{1'b1}}),
        .RST  (RST_ZERO)
    ) u_lower (
        .clock_i  (clock_i),
        .rst_i    (rst_i),
        .set_we_i (we_lo_set),
        .clr_we_i (we_lo_clr),
        .wdata_i  (wdata_i),
        .hw_set_i (RST_ZERO),
        .value_o  (lower_mask)
    );

    // Bit n of the upper word is channel 32+n
    assign iso_rx_enable_o = {upper_mask, lower_mask};

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rx_chan_ok_o <= 1'b0;
        end else begin
            rx_chan_ok_o <= iso_rx_enable_o[rx_chan_i];
        end
    end

    // ==========================================================
    // General-purpose control and interrupt mask
    logic [DATA_W-1:0] gpio_ctrl_q;
    logic [DATA_W-1:0] irq_mask_q;
    logic              gp_irq_a_enable;
    logic              gp_irq_b_enable;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            gpio_ctrl_q <= RST_ZERO;
        end else if (wr_i && addr_i == OFS_GPIO_CTRL) begin
            gpio_ctrl_q <= wdata_i & GPIO_IMPL;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_mask_q <= RST_ZERO;
        end else if (wr_i && addr_i == OFS_IRQ_MASK) begin
            irq_mask_q <= wdata_i & EVENT_IMPL;
        end
    end

    assign gp_irq_a_enable = gpio_ctrl_q[GP_IRQ_A_EN_BIT];
    assign gp_irq_b_enable = gpio_ctrl_q[GP_IRQ_B_EN_BIT];

    // ==========================================================
    // Event sources
    logic [DATA_W-1:0] src_vec;
    logic [DATA_W-1:0] src_rise;
    logic              gp_input_irq_event;

    // Gated before edge detection, so enabling a held-high input raises an event
    assign gp_input_irq_event = (gp_irq_a_i & gp_irq_a_enable)
                              | (gp_irq_b_i & gp_irq_b_enable);

    always_comb begin
        src_vec              = irq_src_i;
        src_vec[EV_GP_INPUT] = gp_input_irq_event;
        src_vec[EV_SOFTWARE] = 1'b0;
    end

    irx_edge_det #(
        .W (DATA_W)
    ) u_edge (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .level_i (src_vec),
        .rise_o  (src_rise)
    );

    // ==========================================================
    // Interrupt event register
    logic [DATA_W-1:0] event_raw;
    logic [DATA_W-1:0] event_vis;

    irx_setclr_reg #(
        .W    (DATA_W),
        .IMPL (EVENT_IMPL),
        .RST  (RST_ZERO)
    ) u_event (
        .clock_i  (clock_i),
        .rst_i    (rst_i),
        .set_we_i (we_ev_set),
        .clr_we_i (we_ev_clr),
        .wdata_i  (wdata_i),
        .hw_set_i (src_rise),
        .value_o  (event_raw)
    );

    assign event_vis = event_raw & irq_mask_q;

    // Level output; drops only after a clear write or an interrupt mask write lands
    assign irq_o = |event_vis;

    // ==========================================================
    // Read data, valid the cycle after the strobe
    logic [DATA_W-1:0] rdata_d;

    always_comb begin
        case (addr_i)
            OFS_UPPER_SET,
            OFS_UPPER_CLR: rdata_d = upper_mask;
            OFS_LOWER_SET,
            OFS_LOWER_CLR: rdata_d = lower_mask;
            OFS_EVENT_SET,
            OFS_EVENT_CLR: rdata_d = event_vis;
            OFS_IRQ_MASK:  rdata_d = irq_mask_q;
            OFS_RAW_EVENT: rdata_d = event_raw;
            OFS_GPIO_CTRL: rdata_d = gpio_ctrl_q;
            default:       rdata_d = RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_o <= RST_ZERO;
        end else if (rd_i) begin
            rdata_o <= rdata_d;
        end else begin
            rdata_o <= RST_ZERO;
        end
    end
endmodule

// [irx_regs_assertions.sv]
// Checker for the iso receive mask and event bank
`timescale 1ns/1ps
module irx_regs_chk
    import irx_pkg::*;
#(
    parameter int unsigned NUM_CH = 64
) (
    // Clock, reset and host port
    input wire logic              clock_i,
    input wire logic              rst_i,
    input wire logic [7:0]        addr_i,
    input wire logic [31:0]       wdata_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [31:0]       rdata_o,
    // Filter and interrupt
    input wire logic [5:0]        rx_chan_i,
    input wire logic              rx_chan_ok_o,
    input wire logic [NUM_CH-1:0] iso_rx_enable_o,
    input wire logic              irq_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    property p_rd_stand;
        !$past(rd_i) |-> rdata_o == 32'h0000_0000;
    endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("read data outside slot");
    property p_up_set;
        wr_i && addr_i == 8'h70 |=> iso_rx_enable_o[63:32] ==
            ($past(iso_rx_enable_o[63:32]) | $past(wdata_i));
    endproperty
    a_up_set: assert property (p_up_set) else $error("upper set wrong");
    property p_up_clr;
        wr_i && addr_i == 8'h74 |=> iso_rx_enable_o[63:32] ==
            ($past(iso_rx_enable_o[63:32]) & ~$past(wdata_i));
    endproperty
    a_up_clr: assert property (p_up_clr) else $error("upper clear wrong");
    property p_lo_set;
        wr_i && addr_i == 8'h78 |=> iso_rx_enable_o[31:0] ==
            ($past(iso_rx_enable_o[31:0]) | $past(wdata_i));
    endproperty
    a_lo_set: assert property (p_lo_set) else $error("lower set wrong");
    property p_lo_clr;
        wr_i && addr_i == 8'h7C |=> iso_rx_enable_o[31:0] ==
            ($past(iso_rx_enable_o[31:0]) & ~$past(wdata_i));
    endproperty
    a_lo_clr: assert property (p_lo_clr) else $error("lower clear wrong");
    property p_rd_up;
        rd_i && addr_i inside {8'h70, 8'h74} |=> rdata_o == $past(iso_rx_enable_o[63:32]);
    endproperty
    a_rd_up: assert property (p_rd_up) else $error("upper read wrong");
    property p_rd_lo;
        rd_i && addr_i inside {8'h78, 8'h7C} |=> rdata_o == $past(iso_rx_enable_o[31:0]);
    endproperty
    a_rd_lo: assert property (p_rd_lo) else $error("lower read wrong");
    property p_chan;
        rx_chan_ok_o == $past(iso_rx_enable_o[rx_chan_i]);
    endproperty
    a_chan: assert property (p_chan) else $error("channel filter wrong");
    property p_ev_hold;
        irq_o && !(wr_i && addr_i inside {8'h84, 8'h88}) |=> irq_o;
    endproperty
    a_ev_hold: assert property (p_ev_hold) else $error("event lost");
endmodule
bind irx_regs irx_regs_chk #(.NUM_CH(NUM_CH)) irx_regs_chk_inst (.clock_i, .rst_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .rx_chan_i, .rx_chan_ok_o, .iso_rx_enable_o, .irq_o);

// [irx_regs_tb.sv]
// Self-checking bench for the iso receive mask and event bank
`timescale 1ns/1ps
module irx_regs_tb;
    import irx_pkg::*;
    logic        clock_i = 0;
    logic        rst_i = 1;
    logic [7:0]  addr_i = 0;
    logic [31:0] wdata_i = 0;
    logic        wr_i = 0;
    logic        rd_i = 0;
    logic [31:0] rdata_o;
    logic [31:0] irq_src_i = 0;
    logic        gp_irq_a_i = 0;
    logic        gp_irq_b_i = 0;
    logic [5:0]  rx_chan_i = 0;
    logic        rx_chan_ok_o;
    logic [63:0] iso_rx_enable_o;
    logic        irq_o;
    logic [63:0] m;
    logic [31:0] d;
    logic [31:0] r;
    logic [7:0]  a;
    int          seed = 51504;
    int          err_total = 0;
    int          checks_done = 0;
    always #2.5 clock_i = ~clock_i;
    irx_regs irx_regs_inst (.clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .irq_src_i, .gp_irq_a_i, .gp_irq_b_i, .rx_chan_i, .rx_chan_ok_o, .iso_rx_enable_o,
        .irq_o);
    function automatic logic [31:0] upd(logic [31:0] v, logic [31:0] w, logic s);
        return s ? (v | w) : (v & ~w);
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        @(posedge clock_i);
        wr_i <= 1;
        addr_i <= ad;
        wdata_i <= dt;
        @(posedge clock_i);
        wr_i <= 0;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [31:0] dt);
        @(posedge clock_i);
        rd_i <= 1;
        addr_i <= ad;
        @(posedge clock_i);
        rd_i <= 0;
        #1 dt = rdata_o;
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #20000;
        err_total++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge clock_i);
        rst_i <= 0;
        m = 0;
        for (int i = 0; i < 24; i++) begin
            a = 8'h70 + 8'(($random(seed) & 3) * 4);
            d = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
            wr(a, d);
            if (a < 8'h78) m[63:32] = upd(m[63:32], d, a == 8'h70);
            else m[31:0] = upd(m[31:0], d, a == 8'h78);
            rd(a ^ 8'h04, r);
            chk(r, (a < 8'h78) ? m[63:32] : m[31:0]);
            @(posedge clock_i);
            rx_chan_i <= 6'($random(seed));
            @(posedge clock_i);
            #1 chk(32'(rx_chan_ok_o), 32'(m[rx_chan_i]));
        end
        chk(iso_rx_enable_o[63:32], m[63:32]);
        chk(iso_rx_enable_o[31:0], m[31:0]);
        rd(8'h90, r);
        chk(r, 32'h0000_0000);
        $display("mask test done");
        wr(OFS_IRQ_MASK, 32'hFFFF_FFFF);
        // Bit 29 and the reserved bits are driven high as well; none may latch
        irq_src_i <= 32'hB000_0008;
        @(posedge clock_i);
        irq_src_i <= 0;
        rd(OFS_EVENT_SET, r);
        chk(r, 32'h0000_0008);
        chk(32'(irq_o), 32'h0000_0001);
        wr(OFS_EVENT_CLR, 32'h0000_0004);
        wr(OFS_EVENT_SET, 32'h2000_0000);
        wr(OFS_GPIO_CTRL, 32'h0080_0000);
        gp_irq_b_i <= 1;
        rd(OFS_RAW_EVENT, r);
        chk(r, 32'h2000_0008);
        @(posedge clock_i);
        gp_irq_a_i <= 1;
        rd(OFS_RAW_EVENT, r);
        chk(r, 32'h6000_0008);
        wr(OFS_IRQ_MASK, 32'h0000_0008);
        rd(OFS_EVENT_CLR, r);
        chk(r, 32'h0000_0008);
        wr(OFS_EVENT_CLR, 32'hFFFF_FFFF);
        rd(OFS_RAW_EVENT, r);
        chk(r, 32'h0000_0000);
        chk(32'(irq_o), 32'h0000_0000);
        $display("event test done");
        summarize();
    end
endmodule
